// [core/twi_port_defs.svh]
`ifndef TWI_PORT_DEFS_SVH
`define TWI_PORT_DEFS_SVH

// Bus address and the two header bytes that follow from it.
`define SLV_ADDR 7'h60
`define HDR_WR 8'hC0
`define HDR_RD 8'hC1

// Command codes of the shared command layer.
`define CMD_RAM_WR 8'h00
`define CMD_RAM_RD 8'h40
`define CMD_PWR_RST 8'hF0
`define CMD_MEAS_RST 8'hC0
`define CMD_CONT_CONV 8'hCC
`define CMD_ONE_CONV 8'hCE
`define CMD_WDT_OFF 8'h9E
`define CMD_WDT_ON 8'h9F
`define CMD_REF_OFF 8'h86
`define CMD_REF_ON 8'h87
`define CMD_UNV_DIS 8'h90
`define CMD_UNV_ENA 8'h91
`define CMD_UNV_RD 8'hA0
`define CMD_UNV_WR 8'hA1
`define CMD_UNV_CLR 8'hA2
`define CMD_UNV_ERASE 8'hA4
`define CMD_PRG_RD 8'hA6
`define CMD_PRG_WR 8'hA7
`define CMD_PRG_DIS 8'hA8
`define CMD_PRG_ENA 8'hA9
`define CMD_PGM_DIS 8'hAC
`define CMD_PGM_ENA 8'hAD

// Byte counts, sizes and the filler value.
`define RAM_DATA_BYTES 2'd3
`define UNV_DEPTH 128
`define UNV_FILLER 8'h00

`endif

// [core/twi_port_pkg.sv]
package twi_port_pkg;

	// One decoded command as handed to the rest of the device.
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] addr;
		logic [23:0] data;
	} cmd_s;

	// Byte engine states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RX = 5'b00010,
		ST_RX_ACK = 5'b00100,
		ST_TX = 5'b01000,
		ST_TX_ACK = 5'b10000
	} byte_st_e;

endpackage : twi_port_pkg

// [core/pin_sync.sv]
`timescale 1ns/100ps

// Two flip-flop synchroniser for one pin; the first stage feeds only the
// second.
module pin_sync (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Pin and synchronised level.
	input wire logic pin,
	output logic level
);

	logic meta_q; // First stage, read by the second stage alone.

	// The reset value is high because an idle bus rests high.
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= 1'b1;
			level <= 1'b1;
		end else begin
			meta_q <= pin;
			level <= meta_q;
		end
	end

endmodule : pin_sync

// [core/twi_cmd_port.sv]
`timescale 1ns/100ps
`include "twi_port_defs.svh"

module twi_cmd_port (
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic RST,
	// Interface select and two-wire pins.
	input wire logic MODE_SEL,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Measurement end and general pin three.
	input wire logic MEAS_DONE,
	input wire logic END_IRQ_EN,
	output logic PIN3_OUT,
	output logic PIN3_OE,
	// Decoded commands towards the device core.
	output twi_port_pkg::cmd_s CMD,
	output logic CMD_VALID,
	output logic RAM_RD_REQ,
	output logic PRG_RD_REQ,
	output logic PRG_WR_REQ,
	output logic EXT_MEM_REQ,
	input wire logic [23:0] RD_DATA,
	// Control levels towards the device core.
	output logic WDT_EN,
	output logic REF_ON,
	output logic UNV_ACCESS,
	output logic PRG_ENA,
	output logic PGM_ENA
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic scl_s, sda_s, mode_s;
	pin_sync u_scl (.clk(CLK_SYS), .rst(RST), .pin(SCL_IN), .level(scl_s));
	pin_sync u_sda (.clk(CLK_SYS), .rst(RST), .pin(SDA_IN), .level(sda_s));
	pin_sync u_mode (.clk(CLK_SYS), .rst(RST), .pin(MODE_SEL),
		.level(mode_s));

	logic scl_q, sda_q; // Previous synchronised levels for edges.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	// Edges and bus conditions; a mode pin low keeps the engine dead.
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = mode_s & scl_s & ~scl_q;
	assign scl_fall = mode_s & ~scl_s & scl_q;
	assign start_c = mode_s & scl_s & scl_q & sda_q & ~sda_s;
	assign stop_c = mode_s & scl_s & scl_q & ~sda_q & sda_s;

	// ------------------------------------------------------------
	// Byte engine
	// ------------------------------------------------------------
	twi_port_pkg::byte_st_e st_q;
	logic [7:0] sh_q;      // Shift register for both directions.
	logic [3:0] bit_q;     // Bits moved within the byte.
	logic hdr_q;           // Next received byte is the header.
	logic rd_dir_q;        // Current transaction reads.
	logic byte_done_d;     // A received byte is complete.
	logic [7:0] rx_byte_d; // That byte.
	logic mack_q;          // Master ack sampled in ninth clock.
	logic [7:0] tx_next;   // Next byte to send.

	assign byte_done_d = (st_q == twi_port_pkg::ST_RX) & scl_rise
		& (bit_q == 4'd7);
	assign rx_byte_d = {sh_q[6:0], sda_s};

	// Walks bits in on rising edges and drives acks and read data.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_q <= twi_port_pkg::ST_IDLE;
			sh_q <= 8'h00;
			bit_q <= 4'd0;
			hdr_q <= 1'b0;
			rd_dir_q <= 1'b0;
			mack_q <= 1'b0;
			SDA_OUT <= 1'b1;
			SDA_OE <= 1'b0;
		end else if (start_c) begin
			st_q <= twi_port_pkg::ST_RX;
			bit_q <= 4'd0;
			hdr_q <= 1'b1;
			SDA_OE <= 1'b0;
		end else if (stop_c) begin
			st_q <= twi_port_pkg::ST_IDLE;
			SDA_OE <= 1'b0;
		end else begin
			case (st_q)
				twi_port_pkg::ST_RX: begin
					if (scl_rise) begin
						sh_q <= rx_byte_d;
						bit_q <= bit_q + 4'd1;
					end
					if (scl_fall && bit_q == 4'd8) begin
						bit_q <= 4'd0;
						if (hdr_q && sh_q[7:1] != `SLV_ADDR) begin
							st_q <= twi_port_pkg::ST_IDLE;
						end else begin
							st_q <= twi_port_pkg::ST_RX_ACK;
							SDA_OUT <= 1'b0;
							SDA_OE <= 1'b1;
							if (hdr_q) begin
								rd_dir_q <= sh_q[0];
							end
							hdr_q <= 1'b0;
						end
					end
				end
				twi_port_pkg::ST_RX_ACK: begin
					if (scl_fall) begin
						if (rd_dir_q) begin
							st_q <= twi_port_pkg::ST_TX;
							sh_q <= {tx_next[6:0], 1'b0};
							SDA_OUT <= tx_next[7];
							SDA_OE <= ~tx_next[7];
							bit_q <= 4'd1;
						end else begin
							st_q <= twi_port_pkg::ST_RX;
							SDA_OE <= 1'b0;
						end
					end
				end
				twi_port_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_q == 4'd8) begin
							st_q <= twi_port_pkg::ST_TX_ACK;
							SDA_OE <= 1'b0;
						end else begin
							SDA_OUT <= sh_q[7];
							SDA_OE <= ~sh_q[7];
							sh_q <= {sh_q[6:0], 1'b0};
							bit_q <= bit_q + 4'd1;
						end
					end
				end
				twi_port_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_s;
					end
					if (scl_fall) begin
						// A master nack ends the read; wait for stop.
						if (mack_q) begin
							st_q <= twi_port_pkg::ST_TX;
							sh_q <= {tx_next[6:0], 1'b0};
							SDA_OUT <= tx_next[7];
							SDA_OE <= ~tx_next[7];
							bit_q <= 4'd1;
						end else begin
							st_q <= twi_port_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					st_q <= twi_port_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Command layer
	// ------------------------------------------------------------
	logic [7:0] op_q;     // Opcode of the current command.
	logic [2:0] cnt_q;    // Bytes received after the header, saturating.
	logic [23:0] dat_q;   // Write data being collected.
	logic [1:0] tx_idx_q; // Read bytes already sent.
	logic [7:0] unv_mem [`UNV_DEPTH]; // User nonvolatile store.
	logic [6:0] unv_a_q;  // Store address for reads.
	logic is_rx_byte;

	// A data byte of a write transaction, never the header.
	assign is_rx_byte = byte_done_d & ~hdr_q & ~rd_dir_q;

	// Collects opcode, address and data, then fires a command.
	// Every start clears the count, so a write after a read never
	// inherits a stale byte position; reads do not use the count.
	// It must reach four so that the third data byte is told apart.
	always_ff @(posedge CLK_SYS) begin
		if (RST || start_c) begin
			cnt_q <= 3'd0;
		end else if (is_rx_byte && cnt_q != 3'd4) begin
			cnt_q <= cnt_q + 3'd1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			op_q <= 8'h00;
			dat_q <= 24'h00_0000;
			unv_a_q <= 7'h00;
			CMD <= '0;
			CMD_VALID <= 1'b0;
			EXT_MEM_REQ <= 1'b0;
			RAM_RD_REQ <= 1'b0;
			PRG_RD_REQ <= 1'b0;
			PRG_WR_REQ <= 1'b0;
		end else begin
			CMD_VALID <= 1'b0;
			EXT_MEM_REQ <= 1'b0;
			RAM_RD_REQ <= 1'b0;
			PRG_RD_REQ <= 1'b0;
			PRG_WR_REQ <= 1'b0;
			if (is_rx_byte) begin
				case (cnt_q)
					3'd0: begin
						op_q <= rx_byte_d;
						CMD <= '{rx_byte_d, 8'h00, 24'h00_0000};
						// Single-byte commands fire at once.
						CMD_VALID <= 1'b1;
						EXT_MEM_REQ <= rx_byte_d[7:4] == 4'h5;
					end
					3'd1: begin
						CMD.addr <= rx_byte_d;
						unv_a_q <= rx_byte_d[6:0];
						RAM_RD_REQ <= op_q == `CMD_RAM_RD;
						PRG_RD_REQ <= op_q == `CMD_PRG_RD;
						EXT_MEM_REQ <= op_q[7:4] == 4'h5;
					end
					default: begin
						dat_q <= {dat_q[15:0], rx_byte_d};
						EXT_MEM_REQ <= op_q[7:4] == 4'h5;
						if (cnt_q == 3'd4 || op_q != `CMD_RAM_WR) begin
							CMD.data <= {dat_q[15:0], rx_byte_d};
							CMD_VALID <= 1'b1;
							PRG_WR_REQ <= op_q == `CMD_PRG_WR;
						end
					end
				endcase
			end
		end
	end

	// User store updates; the clear and erase drop the supplied data.
	always_ff @(posedge CLK_SYS) begin
		if (is_rx_byte && cnt_q == 3'd2) begin
			if (op_q == `CMD_UNV_WR) begin
				unv_mem[CMD.addr[6:0]] <= rx_byte_d;
			end else if (op_q == `CMD_UNV_CLR) begin
				unv_mem[CMD.addr[6:0]] <= `UNV_FILLER;
			end
		end
		if (is_rx_byte && cnt_q == 3'd1 && op_q == `CMD_UNV_ERASE) begin
			for (int i = 0; i < `UNV_DEPTH; i++) begin
				unv_mem[i] <= `UNV_FILLER;
			end
		end
	end

	// Read data order: filler then byte for the store, else MSB first.
	always_ff @(posedge CLK_SYS) begin
		if (RST || start_c) begin
			tx_idx_q <= 2'd0;
		end else if (st_q == twi_port_pkg::ST_TX && scl_fall
			&& bit_q == 4'd8) begin
			tx_idx_q <= tx_idx_q + 2'd1;
		end
	end

	always_comb begin
		if (op_q == `CMD_UNV_RD) begin
			tx_next = (tx_idx_q == 2'd0) ? `UNV_FILLER
				: unv_mem[unv_a_q];
		end else begin
			case (tx_idx_q)
				2'd0: tx_next = RD_DATA[23:16];
				2'd1: tx_next = RD_DATA[15:8];
				default: tx_next = RD_DATA[7:0];
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control levels
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			WDT_EN <= 1'b1;
			REF_ON <= 1'b0;
			UNV_ACCESS <= 1'b0;
			PRG_ENA <= 1'b0;
			PGM_ENA <= 1'b0;
		end else if (is_rx_byte && cnt_q == 3'd0) begin
			case (rx_byte_d)
				`CMD_WDT_OFF: WDT_EN <= 1'b0;
				`CMD_WDT_ON: WDT_EN <= 1'b1;
				`CMD_REF_ON: REF_ON <= 1'b1;
				`CMD_REF_OFF: REF_ON <= 1'b0;
				`CMD_UNV_ENA: UNV_ACCESS <= 1'b1;
				`CMD_UNV_DIS: UNV_ACCESS <= 1'b0;
				`CMD_PRG_ENA: PRG_ENA <= 1'b1;
				`CMD_PRG_DIS: PRG_ENA <= 1'b0;
				`CMD_PGM_ENA: PGM_ENA <= 1'b1;
				`CMD_PGM_DIS: PGM_ENA <= 1'b0;
				default: WDT_EN <= WDT_EN;
			endcase
		end
	end

	// Measurement end pulls pin three low until the next opcode.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PIN3_OUT <= 1'b1;
			PIN3_OE <= 1'b0;
		end else begin
			PIN3_OE <= mode_s & END_IRQ_EN;
			if (MEAS_DONE) begin
				PIN3_OUT <= 1'b0;
			end else if (is_rx_byte && cnt_q == 3'd0) begin
				PIN3_OUT <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_foreign_addr_ignored: assert property (@(posedge CLK_SYS)
		disable iff (RST) (st_q == twi_port_pkg::ST_RX && hdr_q && scl_fall
		&& bit_q == 4'd8 && sh_q[7:1] != `SLV_ADDR && !start_c && !stop_c)
		|=> !SDA_OE) else $error("Foreign address was acknowledged.");
	a_wdt_off_cmd: assert property (@(posedge CLK_SYS)
		disable iff (RST) (is_rx_byte && cnt_q == 3'd0
		&& rx_byte_d == `CMD_WDT_OFF) |=> !WDT_EN)
		else $error("Timer stayed on after off command.");
	a_ack_driven_low: assert property (@(posedge CLK_SYS)
		disable iff (RST) (st_q == twi_port_pkg::ST_RX_ACK) |-> (SDA_OE
		&& !SDA_OUT)) else $error("Ack not driven low.");
	a_mode_gates_bus: assert property (@(posedge CLK_SYS)
		disable iff (RST) !mode_s |-> !scl_rise && !start_c)
		else $error("Engine active with mode pin low.");
	a_meas_end_low: assert property (@(posedge CLK_SYS)
		disable iff (RST) MEAS_DONE |=> !PIN3_OUT)
		else $error("Pin three did not fall.");
	a_idle_released: assert property (@(posedge CLK_SYS)
		disable iff (RST) $rose(st_q == twi_port_pkg::ST_IDLE) |-> !SDA_OE
		|| $past(st_q) == twi_port_pkg::ST_IDLE)
		else $error("Data line held after idle.");
	a_ramwr_three: assert property (@(posedge CLK_SYS)
		disable iff (RST) (is_rx_byte && (cnt_q == 3'd2 || cnt_q == 3'd3)
		&& op_q == `CMD_RAM_WR) |=> !CMD_VALID)
		else $error("RAM write fired early.");
	a_ram_rd_req: assert property (@(posedge CLK_SYS)
		disable iff (RST) (is_rx_byte && cnt_q == 3'd1 && op_q == `CMD_RAM_RD)
		|=> RAM_RD_REQ) else $error("RAM read not requested.");

endmodule : twi_cmd_port

// [bench/twi_master_model.sv]
`timescale 1ns/100ps

// -------------------------------------------------------------
// Bus master model
// -------------------------------------------------------------
// Sole master on the bus, so no arbitration is modelled
module twi_master_model (
	// System clock paces the bus phases.
	input wire logic clk,
	// Data line as seen on the wire.
	input wire logic sda,
	// Clock line and data pull-down; a 1 releases to the pull-up.
	output logic scl,
	output logic sda_drv
);
	// Phase length in clocks; the port needs four, margin is kept.
	localparam int PH = 10;

	// Both lines rest released between frames.
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// Waits out one bus phase.
	task automatic ph();
		repeat (PH) @(posedge clk);
	endtask : ph

	// One bit. Data moves two clocks after the fall, so it never
	// passes for a start or stop, and is settled at the rise.
	task automatic bit_io(input logic d, output logic s);
		repeat (2) @(posedge clk);
		sda_drv <= d;
		ph();
		scl <= 1'b1;
		ph();
		s = sda;
		scl <= 1'b0;
	endtask : bit_io

	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		repeat (2) @(posedge clk);
		sda_drv <= 1'b1;
		ph();
		scl <= 1'b1;
		ph();
		sda_drv <= 1'b0;
		ph();
		scl <= 1'b0;
	endtask : start

	// Stop: data rises while the clock is high, then the bus idles.
	task automatic stop();
		repeat (2) @(posedge clk);
		sda_drv <= 1'b0;
		ph();
		scl <= 1'b1;
		ph();
		sda_drv <= 1'b1;
		ph();
	endtask : stop

	// Byte out, MSB first; ack is 1 when the slave pulled bit nine.
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wr_byte

	// Byte in, MSB first; the last byte is refused to end the read.
	task automatic rd_byte(output logic [7:0] b, input logic last);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(last, s);
	endtask : rd_byte

endmodule : twi_master_model

// [bench/two_wire_slave_command_port_tb.sv]
`timescale 1ns/100ps
`include "twi_port_defs.svh"

// Counts a comparison and reports a mismatch at once.
`define CHECK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	n_errors++; $display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
	end end

module two_wire_slave_command_port_tb;
	// -----------------------------------------------------------
	// Signals
	// -----------------------------------------------------------
	// Bytes of one frame.
	typedef logic [7:0] bq_t[$];
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mode = 1'b1;
	logic meas_done = 1'b0;
	logic irq_en = 1'b0;
	logic [23:0] rd_data = 24'h00_0000;
	// The data line is wired-AND with its pull-up.
	logic scl, m_sda, sda_out, sda_oe, pin3_out, pin3_oe, cmd_valid;
	wire sda = (sda_oe ? sda_out : 1'b1) & m_sda;
	logic ram_rd, prg_rd, prg_wr, ext_req;
	logic wdt_en, ref_on, unv, prg_ena, pgm_ena;
	wire [4:0] lv_seen = {wdt_en, ref_on, unv, prg_ena, pgm_ena};
	twi_port_pkg::cmd_s cmd, last_q;
	int n_errors = 0;
	int checks_done = 0;
	int n_valid = 0;
	int n_req[4] = '{0, 0, 0, 0};
	int seed = 1199;
	// Off/on pairs, one pair per control level, highest level first.
	logic [7:0] lvl_op[10] = '{`CMD_WDT_OFF, `CMD_WDT_ON, `CMD_REF_OFF,
		`CMD_REF_ON, `CMD_UNV_DIS, `CMD_UNV_ENA, `CMD_PRG_DIS,
		`CMD_PRG_ENA, `CMD_PGM_DIS, `CMD_PGM_ENA};
	logic [7:0] trg_op[4] = '{`CMD_PWR_RST, `CMD_MEAS_RST,
		`CMD_CONT_CONV, `CMD_ONE_CONV};
	logic [7:0] rd_op[2] = '{`CMD_RAM_RD, `CMD_PRG_RD};

	always #4 clk = ~clk;

	twi_cmd_port dut_u (
		.CLK_SYS(clk), .RST(rst), .MODE_SEL(mode), .SCL_IN(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.MEAS_DONE(meas_done), .END_IRQ_EN(irq_en), .PIN3_OUT(pin3_out),
		.PIN3_OE(pin3_oe), .CMD(cmd), .CMD_VALID(cmd_valid),
		.RAM_RD_REQ(ram_rd), .PRG_RD_REQ(prg_rd), .PRG_WR_REQ(prg_wr),
		.EXT_MEM_REQ(ext_req), .RD_DATA(rd_data), .WDT_EN(wdt_en),
		.REF_ON(ref_on), .UNV_ACCESS(unv), .PRG_ENA(prg_ena),
		.PGM_ENA(pgm_ena)
	);
	twi_master_model m_u (.clk(clk), .sda(sda), .scl(scl), .sda_drv(m_sda));

	// Keeps the last command handed on and counts request pulses.
	always @(posedge clk) begin
		if (cmd_valid === 1'b1) begin
			last_q <= cmd;
			n_valid <= n_valid + 1;
		end
		n_req[0] <= n_req[0] + (ram_rd === 1'b1);
		n_req[1] <= n_req[1] + (prg_rd === 1'b1);
		n_req[2] <= n_req[2] + (prg_wr === 1'b1);
		n_req[3] <= n_req[3] + (ext_req === 1'b1);
	end

	// -----------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------
	task automatic give_verdict();
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	// Start, then bytes that must each be acknowledged.
	task automatic frame(input bq_t q);
		logic a;
		m_u.start();
		foreach (q[i]) begin
			m_u.wr_byte(q[i], a);
			`CHECK("ack", 1'b1, a)
		end
	endtask : frame

	task automatic send(input bq_t q);
		frame(q);
		m_u.stop();
	endtask : send

	// Write part, repeated start, then n bytes read MSB first.
	task automatic fetch(input bq_t q, input int n, output logic [23:0] v);
		logic [7:0] b;
		frame(q);
		frame('{`HDR_RD});
		v = 24'h00_0000;
		for (int i = 0; i < n; i++) begin
			m_u.rd_byte(b, i == n - 1);
			v = {v[15:0], b};
		end
		m_u.stop();
	endtask : fetch

	// -----------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------
	initial begin
		logic [23:0] v;
		logic [7:0] a, d, h;
		logic ak;
		logic [4:0] lv;
		int k, nv;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Short settling gap stands in for the power-up wait
		repeat (8) @(posedge clk);
		`CHECK("levels", 5'b10000, lv_seen)
		`CHECK("idle oe", 1'b0, sda_oe)
		// Foreign addresses, a neighbour of ours first, are ignored.
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 8'h61 : 8'($random(seed));
			if (a[6:0] == `SLV_ADDR)
				a = 8'h62;
			m_u.start();
			m_u.wr_byte({a[6:0], 1'b0}, ak);
			m_u.stop();
			`CHECK("foreign ack", 1'b0, ak)
		end
		// With the select pin low the pins are not the bus.
		mode <= 1'b0;
		repeat (8) @(posedge clk);
		m_u.start();
		m_u.wr_byte(`HDR_WR, ak);
		m_u.stop();
		`CHECK("mode ack", 1'b0, ak)
		mode <= 1'b1;
		repeat (8) @(posedge clk);
		// Level commands in random order.
		lv = 5'b10000;
		for (int i = 0; i < 16; i++) begin
			k = {$random(seed)} % 10;
			send('{`HDR_WR, lvl_op[k]});
			lv[4 - k / 2] = k[0];
			`CHECK("levels", lv, lv_seen)
		end
		foreach (trg_op[i]) begin
			nv = n_valid;
			send('{`HDR_WR, trg_op[i]});
			`CHECK("pulses", nv + 1, n_valid)
			`CHECK("opcode", trg_op[i], last_q.opcode)
		end
		// Working-RAM writes hand on one whole word.
		repeat (4) begin
			a = $random(seed);
			v = $random(seed);
			nv = n_valid;
			send('{`HDR_WR, `CMD_RAM_WR, a, v[23:16], v[15:8], v[7:0]});
			`CHECK("ram write", {`CMD_RAM_WR, a, v}, last_q)
			// One pulse for the opcode itself, one for the whole word.
			`CHECK("ram pulses", nv + 2, n_valid)
		end
		foreach (rd_op[i]) begin
			rd_data <= $random(seed);
			a = $random(seed);
			@(posedge clk);
			nv = n_req[i];
			fetch('{`HDR_WR, rd_op[i], a}, 3, v);
			`CHECK("read word", rd_data, v)
			`CHECK("read request", nv + 1, n_req[i])
		end
		// User store: enable, write, read back, clear, erase.
		send('{`HDR_WR, `CMD_REF_ON});
		send('{`HDR_WR, `CMD_UNV_ENA});
		a = $random(seed);
		a[7] = 1'b0;
		if (a == 8'h7F)
			a = 8'h00;
		d = $random(seed);
		d[0] = 1'b1;
		h = $random(seed);
		h[0] = 1'b1;
		send('{`HDR_WR, `CMD_UNV_WR, a, d});
		send('{`HDR_WR, `CMD_UNV_WR, 8'h7F, h});
		fetch('{`HDR_WR, `CMD_UNV_RD, a}, 2, v);
		`CHECK("store read", {8'h00, d}, v[15:0])
		send('{`HDR_WR, `CMD_UNV_CLR, a, 8'hFF});
		fetch('{`HDR_WR, `CMD_UNV_RD, a}, 2, v);
		`CHECK("cleared", 16'h0000, v[15:0])
		fetch('{`HDR_WR, `CMD_UNV_RD, 8'h7F}, 2, v);
		`CHECK("kept", {8'h00, h}, v[15:0])
		send('{`HDR_WR, `CMD_UNV_ERASE, 8'h3C, 8'h5A});
		fetch('{`HDR_WR, `CMD_UNV_RD, 8'h7F}, 2, v);
		`CHECK("erased", 16'h0000, v[15:0])
		// Program store write after both enables; external access.
		send('{`HDR_WR, `CMD_PRG_ENA});
		send('{`HDR_WR, `CMD_PGM_ENA});
		nv = n_req[2];
		send('{`HDR_WR, `CMD_PRG_WR, a, d});
		`CHECK("prog write", nv + 1, n_req[2])
		nv = n_req[3];
		send('{`HDR_WR, 8'h53, 8'h06});
		`CHECK("ext pass", 1'b1, n_req[3] > nv)
		// Measurement end on pin three, cleared by the next opcode.
		irq_en <= 1'b1;
		meas_done <= 1'b1;
		@(posedge clk);
		meas_done <= 1'b0;
		k = 0;
		while (pin3_out !== 1'b0 && k < 8) begin
			@(posedge clk);
			k++;
		end
		`CHECK("pin3 low", 1'b0, pin3_out)
		if (k == 8)
			give_verdict();
		`CHECK("pin3 drive", 1'b1, pin3_oe)
		send('{`HDR_WR, `CMD_WDT_ON});
		`CHECK("pin3 back", 1'b1, pin3_out)
		`CHECK("idle line", 1'b1, sda)
		give_verdict();
	end

endmodule : two_wire_slave_command_port_tb
